// *** hw/fcs_cfg.svh ***
// Purpose: Constants of the bus cycle sync PLL
// Assumes: 50 MHz pclk
// Notes:   Times in their own unit, cycle counts derived
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_CLK_NS       20
`define FCS_TICK_NS      62500
`define FCS_ADJ_NS       300
`define FCS_TICK_CYC     (`FCS_TICK_NS / `FCS_CLK_NS)
`define FCS_ADJ_CYC      (`FCS_ADJ_NS / `FCS_CLK_NS)
`define FCS_MIN_CYC_NS   250000
`define FCS_MIN_TICKS    ((`FCS_MIN_CYC_NS + `FCS_TICK_NS - 1) / `FCS_TICK_NS)
`define FCS_EXP_MIN      (-6)
`define FCS_EXP_MAX      (-1)
// Register byte offsets
`define FCS_A_CTRL       8'h00
`define FCS_A_EXPD       8'h04
`define FCS_A_WND        8'h08
`define FCS_A_THR        8'h0C
`define FCS_A_CYC        8'h10
`define FCS_A_TICKS      8'h14
`define FCS_A_MEAS       8'h18
`define FCS_A_STAT       8'h1C
`define FCS_A_MODE       8'h20
`define FCS_A_IRQ_ST     8'h24
`define FCS_A_IRQ_EN     8'h28
`define FCS_A_IRQ_CLR    8'h2C
// Field positions
`define FCS_B_SYNC_EN    0
`define FCS_B_DC_MODE    1
`define FCS_B_LOCKED     16
`define FCS_I_LOCK_GAIN  0
`define FCS_I_LOCK_LOST  1
`define FCS_I_REF_MISS   2
`define FCS_I_CYC_SHORT  3
// Reset values
`define FCS_R_CTRL       2'h2
`define FCS_R_EXPD       24'h0003E8
`define FCS_R_WND        24'h000032
`define FCS_R_THR        16'h0008
`define FCS_R_UNITS      8'h02
`define FCS_R_EXP        8'hFD
`define FCS_R_TICKS      16'h0020
// Operation mode codes
`define FCS_OPM_PP       8'h01
`define FCS_OPM_PV       8'h03
`define FCS_OPM_TQ       8'h04
`define FCS_OPM_HM       8'h06
`define FCS_OPM_IP       8'h07
`define FCS_OPM_CSP      8'h08
`endif

// *** hw/fcs_pkg.sv ***
// Purpose: Types of the bus cycle sync PLL
// Assumes: Nothing
// Notes:   Mode enum is decoded from the setpoint code
package fcs_pkg;
    typedef enum logic [2:0] {
        FCS_MODE_NONE, FCS_MODE_PROF_POS, FCS_MODE_PROF_VEL, FCS_MODE_TORQUE,
        FCS_MODE_HOMING, FCS_MODE_INTERP_POS, FCS_MODE_CYC_SYNC_POS
    } fcs_mode_e;
endpackage

// *** hw/fcs_sync_pll.sv ***
// Purpose: Locks the 62.5 us tick to the fieldbus master cycle
// Assumes: APB slave, zero wait states, event pins asynchronous
// Notes:   One tick per bus cycle carries the phase correction
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "fcs_cfg.svh"
module fcs_sync_pll
    import fcs_pkg::*;
#(
    parameter int PW = 24
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              clock_sync_event,
    input  wire logic              process_data_arrival_event,
    input  wire logic              net_operational,
    output logic                   realtime_tick_strobe,
    output logic                   interp_sample_strobe,
    output fcs_pkg::fcs_mode_e     control_loop_selector,
    output logic                   sync_locked,
    output logic                   irq
);
    import fcs_pkg::*;
    localparam int TW = 13;
    localparam logic [TW-1:0] TICK = TW'(`FCS_TICK_CYC);
    localparam logic [TW-1:0] ADJ  = TW'(`FCS_ADJ_CYC);
    localparam int PMIN = `FCS_TICK_CYC - `FCS_ADJ_CYC - 1;
    localparam int PMAX = `FCS_TICK_CYC + `FCS_ADJ_CYC - 1;
    localparam int PNOM = `FCS_TICK_CYC - 1;

    // Ticks of a cycle time given as units and power of ten
    function automatic logic [15:0] cyc_to_ticks(input logic [7:0] u, input logic [7:0] e);
        logic [63:0] ns;
        logic [63:0] t;
        ns = 64'(u);
        for (int i = `FCS_EXP_MIN; i < 0; i++) begin
            if (i < $signed(e))
                ns = ns * 64'd10;
        end
        ns = ns * 64'd1000;
        t = ns / 64'(`FCS_TICK_NS);
        cyc_to_ticks = (t > 64'h0FFFF) ? 16'hFFFF : t[15:0];
    endfunction

    // Operation mode from the setpoint code
    function automatic fcs_mode_e opm_decode(input logic [7:0] c);
        unique case (c)
            `FCS_OPM_PP:  opm_decode = FCS_MODE_PROF_POS;
            `FCS_OPM_PV:  opm_decode = FCS_MODE_PROF_VEL;
            `FCS_OPM_TQ:  opm_decode = FCS_MODE_TORQUE;
            `FCS_OPM_HM:  opm_decode = FCS_MODE_HOMING;
            `FCS_OPM_IP:  opm_decode = FCS_MODE_INTERP_POS;
            `FCS_OPM_CSP: opm_decode = FCS_MODE_CYC_SYNC_POS;
            default:      opm_decode = FCS_MODE_NONE;
        endcase
    endfunction

    logic [1:0]      ctrl_ff;
    logic [23:0]     expd_ff;
    logic [23:0]     wnd_ff;
    logic [15:0]     thr_ff;
    logic [7:0]      units_ff;
    logic [7:0]      exp_ff;
    logic [15:0]     ticks_ff;
    logic [7:0]      opcode_ff;
    logic [3:0]      irq_st_ff;
    logic [3:0]      irq_en_ff;
    logic [31:0]     prdata_ff;
    logic [2:0]      cs_sync_ff;
    logic [2:0]      pd_sync_ff;
    logic [1:0]      op_sync_ff;
    logic [PW-1:0]   phase_ff;
    logic [PW-1:0]   meas_ff;
    logic            ref_seen_ff;
    logic [TW-1:0]   tick_cnt_ff;
    logic [15:0]     tick_idx_ff;
    logic            tick_strobe_ff;
    logic            interp_ff;
    logic [15:0]     lock_cnt_ff;
    logic            locked_ff;
    fcs_mode_e       mode_ff;

    logic            wr;
    logic            rd_setup;
    logic            mapped;
    logic            sync_en;
    logic            dc_mode;
    logic            ref_evt;
    logic            pll_pt;
    logic            active;
    logic            in_win;
    logic            cyc_short;
    logic signed [PW+1:0] err;
    logic [TW-1:0]   nxt_period;
    logic [3:0]      irq_set;
    logic [15:0]     nxt_lock_cnt;

    ////////////////////////////////////////////////////////////////////////
    // APB decode, zero wait states
    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_ff;
    assign sync_en  = ctrl_ff[`FCS_B_SYNC_EN];
    assign dc_mode  = ctrl_ff[`FCS_B_DC_MODE];

    always_comb begin
        unique case (paddr)
            `FCS_A_CTRL, `FCS_A_EXPD, `FCS_A_WND, `FCS_A_THR, `FCS_A_CYC,
            `FCS_A_TICKS, `FCS_A_MEAS, `FCS_A_STAT, `FCS_A_MODE,
            `FCS_A_IRQ_ST, `FCS_A_IRQ_EN, `FCS_A_IRQ_CLR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (rd_setup) begin
            unique case (paddr)
                `FCS_A_CTRL:   prdata_ff <= 32'(ctrl_ff);
                `FCS_A_EXPD:   prdata_ff <= 32'(expd_ff);
                `FCS_A_WND:    prdata_ff <= 32'(wnd_ff);
                `FCS_A_THR:    prdata_ff <= 32'(thr_ff);
                `FCS_A_CYC:    prdata_ff <= {16'h0, exp_ff, units_ff};
                `FCS_A_TICKS:  prdata_ff <= 32'(ticks_ff);
                `FCS_A_MEAS:   prdata_ff <= 32'(meas_ff);
                `FCS_A_STAT:   prdata_ff <= {15'h0, locked_ff, lock_cnt_ff};
                `FCS_A_MODE:   prdata_ff <= {21'h0, 3'(mode_ff), opcode_ff};
                `FCS_A_IRQ_ST: prdata_ff <= 32'(irq_st_ff);
                `FCS_A_IRQ_EN: prdata_ff <= 32'(irq_en_ff);
                default:       prdata_ff <= 32'h0;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= `FCS_R_CTRL;
            expd_ff   <= `FCS_R_EXPD;
            wnd_ff    <= `FCS_R_WND;
            thr_ff    <= `FCS_R_THR;
            units_ff  <= `FCS_R_UNITS;
            exp_ff    <= `FCS_R_EXP;
            ticks_ff  <= `FCS_R_TICKS;
            opcode_ff <= 8'h00;
            irq_en_ff <= 4'h0;
        end else if (wr) begin
            unique case (paddr)
                `FCS_A_CTRL:   ctrl_ff <= pwdata[1:0];
                `FCS_A_EXPD:   expd_ff <= pwdata[23:0];
                `FCS_A_WND:    wnd_ff <= pwdata[23:0];
                `FCS_A_THR:    thr_ff <= pwdata[15:0];
                `FCS_A_CYC: begin
                    units_ff <= pwdata[7:0];
                    exp_ff   <= pwdata[15:8];
                    if ($signed(pwdata[15:8]) >= `FCS_EXP_MIN &&
                        $signed(pwdata[15:8]) <= `FCS_EXP_MAX)
                        ticks_ff <= cyc_to_ticks(pwdata[7:0], pwdata[15:8]);
                end
                `FCS_A_TICKS:  ticks_ff <= pwdata[15:0];
                `FCS_A_MODE:   opcode_ff <= pwdata[7:0];
                `FCS_A_IRQ_EN: irq_en_ff <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event pins: two flops, then edge detect on the later stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync_ff <= 3'h0;
            pd_sync_ff <= 3'h0;
            op_sync_ff <= 2'h0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], clock_sync_event};
            pd_sync_ff <= {pd_sync_ff[1:0], process_data_arrival_event};
            op_sync_ff <= {op_sync_ff[0], net_operational};
        end
    end

    // Reference is the clock sync event in DC mode, else data arrival while operational
    assign ref_evt = dc_mode ? (cs_sync_ff[1] && !cs_sync_ff[2])
                   : (pd_sync_ff[1] && !pd_sync_ff[2] && op_sync_ff[1]);

    // Phase counter cleared by the reference, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            phase_ff <= '0;
        else if (ref_evt)
            phase_ff <= '0;
        else if (phase_ff != '1)
            phase_ff <= phase_ff + PW'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Correction point: first tick of every bus cycle
    assign pll_pt = (tick_cnt_ff == '0) && (tick_idx_ff == 16'h0);
    assign active = sync_en && ref_seen_ff;
    assign err    = $signed({2'b00, phase_ff}) - $signed({{(PW-22){1'b0}}, expd_ff});
    assign in_win = ref_seen_ff &&
                    ({2'b00, phase_ff} + {2'b00, wnd_ff} > {2'b00, expd_ff}) &&
                    ({2'b00, phase_ff} < {2'b00, expd_ff} + {2'b00, wnd_ff});

    // Late phase shortens, early phase lengthens the next tick
    always_comb begin
        nxt_period = TICK;
        if (pll_pt && active) begin
            if (err > $signed((PW+2)'(ADJ)))
                nxt_period = TICK - ADJ;
            else if (err < -$signed((PW+2)'(ADJ)))
                nxt_period = TICK + ADJ;
            else
                nxt_period = TICK - TW'(err);
        end
    end

    // Reference seen since the last correction point; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ref_seen_ff <= 1'b0;
        else if (ref_evt)
            ref_seen_ff <= 1'b1;
        else if (pll_pt)
            ref_seen_ff <= 1'b0;
    end

    // Measured delay sampled at the correction point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            meas_ff <= '0;
        else if (pll_pt)
            meas_ff <= phase_ff;
    end

    // Tick generator and tick index within the bus cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff    <= TICK - TW'(1);
            tick_idx_ff    <= 16'h0;
            tick_strobe_ff <= 1'b0;
            interp_ff      <= 1'b0;
        end else begin
            tick_strobe_ff <= (tick_cnt_ff == '0);
            interp_ff      <= pll_pt && (mode_ff == FCS_MODE_INTERP_POS);
            if (tick_cnt_ff == '0) begin
                tick_cnt_ff <= nxt_period - TW'(1);
                if (tick_idx_ff + 16'h1 >= ticks_ff)
                    tick_idx_ff <= 16'h0;
                else
                    tick_idx_ff <= tick_idx_ff + 16'h1;
            end else begin
                tick_cnt_ff <= tick_cnt_ff - TW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock counter
    assign nxt_lock_cnt = (lock_cnt_ff == 16'hFFFF) ? lock_cnt_ff : lock_cnt_ff + 16'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_ff <= 16'h0;
            locked_ff   <= 1'b0;
        end else if (!sync_en) begin
            lock_cnt_ff <= 16'h0;
            locked_ff   <= 1'b0;
        end else if (pll_pt) begin
            if (in_win) begin
                lock_cnt_ff <= nxt_lock_cnt;
                locked_ff   <= (nxt_lock_cnt >= thr_ff);
            end else begin
                lock_cnt_ff <= 16'h0;
                locked_ff   <= 1'b0;
            end
        end
    end

    // Mode decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode_ff <= FCS_MODE_NONE;
        else
            mode_ff <= opm_decode(opcode_ff);
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, set wins over clear
    assign cyc_short = (ticks_ff < 16'(`FCS_MIN_TICKS)) &&
                       (mode_ff inside {FCS_MODE_PROF_POS, FCS_MODE_PROF_VEL,
                        FCS_MODE_TORQUE, FCS_MODE_INTERP_POS, FCS_MODE_CYC_SYNC_POS});

    always_comb begin
        irq_set = 4'h0;
        irq_set[`FCS_I_LOCK_GAIN] = pll_pt && sync_en && in_win && !locked_ff &&
                                    (nxt_lock_cnt >= thr_ff);
        irq_set[`FCS_I_LOCK_LOST] = pll_pt && locked_ff && !in_win;
        irq_set[`FCS_I_REF_MISS]  = pll_pt && sync_en && !ref_seen_ff;
        irq_set[`FCS_I_CYC_SHORT] = cyc_short;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_st_ff <= 4'h0;
        else if (wr && paddr == `FCS_A_IRQ_CLR)
            irq_st_ff <= (irq_st_ff & ~pwdata[3:0]) | irq_set;
        else
            irq_st_ff <= irq_st_ff | irq_set;
    end

    assign irq                   = |(irq_st_ff & irq_en_ff);
    assign realtime_tick_strobe  = tick_strobe_ff;
    assign interp_sample_strobe  = interp_ff;
    assign control_loop_selector = mode_ff;
    assign sync_locked           = locked_ff;

    ////////////////////////////////////////////////////////////////////////
    // Helper: cycles between strobes and enable history
    logic [TW-1:0] gap_ff;
    logic          first_ff;
    logic          en_seen_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_ff     <= '0;
            first_ff   <= 1'b0;
            en_seen_ff <= 1'b0;
        end else if (tick_strobe_ff) begin
            gap_ff     <= '0;
            first_ff   <= 1'b1;
            en_seen_ff <= sync_en;
        end else begin
            gap_ff     <= gap_ff + TW'(1);
            en_seen_ff <= en_seen_ff | sync_en;
        end
    end

    tick_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_strobe_ff && first_ff) |-> (gap_ff >= PMIN && gap_ff <= PMAX))
        else $error("tick period outside 300 ns bound");
    tick_nominal_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_strobe_ff && first_ff && !en_seen_ff && !sync_en) |-> gap_ff == PNOM)
        else $error("tick not nominal while disabled");
    meas_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        pll_pt |=> meas_ff == $past(phase_ff))
        else $error("measured delay not sampled");
    phase_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (dc_mode && cs_sync_ff[1] && !cs_sync_ff[2]) |=> phase_ff == '0)
        else $error("phase not cleared by sync event");
    pd_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!dc_mode && ref_evt) |-> op_sync_ff[1] ##1 phase_ff == '0)
        else $error("data arrival reference wrong");
    adj_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pll_pt && active && err > 0) |=> tick_cnt_ff < TICK - TW'(1))
        else $error("late phase did not shorten tick");
    lock_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pll_pt && sync_en && !in_win) |=> (!locked_ff && lock_cnt_ff == 16'h0))
        else $error("lock kept after miss");
    lock_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        locked_ff |-> lock_cnt_ff >= thr_ff)
        else $error("locked below threshold");
    mode_ip_a: assert property (@(posedge pclk) disable iff (!presetn)
        (opcode_ff == `FCS_OPM_IP) |=> mode_ff == FCS_MODE_INTERP_POS)
        else $error("mode 7 not decoded");
    interp_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        interp_sample_strobe |-> $past(pll_pt))
        else $error("interp strobe off cycle start");
endmodule

// *** dv/fcs_bus_master_model.sv ***
// Purpose: Fieldbus master issuing one reference event per bus cycle
// Assumes: Events are plain pulses, period in pclk cycles
// Notes:   Event pins stay low while traffic is stopped; net_operational follows oper
`timescale 1ns/100ps
module fcs_bus_master_model #(
    parameter int PERIOD = 3125,
    parameter int WIDTH  = 4
) (
    input  wire logic pclk,
    input  wire logic run,
    input  wire logic use_dc,
    input  wire logic oper,
    output logic      clock_sync_event,
    output logic      process_data_arrival_event,
    output logic      net_operational
);
    int cnt_ff = 0;

    ////////////////////////////////////////////////////////////////////
    // Master cycle counter, restarts when traffic starts
    always_ff @(posedge pclk) begin
        if (!run || cnt_ff == PERIOD - 1) begin
            cnt_ff <= 0;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One pulse per cycle on the selected reference pin
    assign clock_sync_event           = run && use_dc && cnt_ff < WIDTH;
    assign process_data_arrival_event = run && !use_dc && cnt_ff < WIDTH;
    assign net_operational            = oper;
endmodule

// *** dv/fcs_sync_pll_bench.sv ***
// Purpose: Self-checking bench of the bus cycle sync PLL
// Assumes: Zero wait APB, one tick per bus cycle in the lock cases
// Notes:   Register rows first, then lock, loss and correction
`timescale 1ns/100ps
`include "fcs_cfg.svh"
module fcs_sync_pll_bench import fcs_pkg::*;;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} fcs_row_s;
    localparam int NOM = `FCS_TICK_CYC;
    localparam int ADJ = `FCS_ADJ_CYC;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, m1;
    logic        run, use_dc, oper, csev, pdev, netop, tick, interp, locked, irq, er;
    fcs_mode_e   sel;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          n_interp = 0;
    int          n, i0;
    logic [7:0]  codes [7] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h02};
    fcs_mode_e   modes [7] = '{FCS_MODE_PROF_POS, FCS_MODE_PROF_VEL, FCS_MODE_TORQUE,
        FCS_MODE_HOMING, FCS_MODE_INTERP_POS, FCS_MODE_CYC_SYNC_POS, FCS_MODE_NONE};
    fcs_row_s    rows [15] = '{
        '{0, `FCS_A_CTRL, 0, {30'h0, `FCS_R_CTRL}, 0},
        '{0, `FCS_A_EXPD, 0, {8'h0, `FCS_R_EXPD}, 0},
        '{0, `FCS_A_WND, 0, {8'h0, `FCS_R_WND}, 0},
        '{0, `FCS_A_THR, 0, {16'h0, `FCS_R_THR}, 0},
        '{0, `FCS_A_CYC, 0, 32'h0000FD02, 0},
        '{0, `FCS_A_TICKS, 0, 32'h20, 0},
        '{1, `FCS_A_CYC, 32'h0000FC05, 0, 0},
        '{0, `FCS_A_TICKS, 0, 32'h8, 0},
        '{1, `FCS_A_CYC, 32'h0000FAFA, 0, 0},
        '{0, `FCS_A_TICKS, 0, 32'h4, 0},
        '{1, `FCS_A_CYC, 32'h00000001, 0, 0},
        '{0, `FCS_A_TICKS, 0, 32'h4, 0},
        '{0, 8'h30, 0, 0, 1},
        '{1, 8'h30, 32'hFFFF, 0, 1},
        '{0, `FCS_A_IRQ_CLR, 0, 0, 0}};

    fcs_sync_pll fcs_sync_pll_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_sync_event(csev),
        .process_data_arrival_event(pdev), .net_operational(netop),
        .realtime_tick_strobe(tick), .interp_sample_strobe(interp),
        .control_loop_selector(sel), .sync_locked(locked), .irq(irq));
    fcs_bus_master_model fcs_bus_master_model_inst (.pclk(pclk), .run(run),
        .use_dc(use_dc), .oper(oper), .clock_sync_event(csev),
        .process_data_arrival_event(pdev), .net_operational(netop));

    ////////////////////////////////////////////////////////////////////
    // Clock, strobe counting and hang guard
    initial begin
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (interp === 1'b1) n_interp++;
        if (cycles == 99000) begin
            bad_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cycles from now to the next tick strobe
    task automatic wait_tick(output int gap);
        gap = 0;
        do begin
            @(posedge pclk);
            gap++;
        end while (tick !== 1'b1);
    endtask
    // Start master traffic so the event leads the next tick by about lead cycles
    task automatic start_master(input logic dc, input int lead);
        run <= 1'b0;
        wait_tick(n);
        repeat (NOM - lead - 3) @(posedge pclk);
        use_dc <= dc;
        run    <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, run} = 5'h0;
        {paddr, pwdata} = 40'h0;
        {use_dc, oper} = 2'h3;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
            if (!rows[i].w) chk("read", rows[i].x, rd);
        end
        foreach (codes[i]) begin
            apb(1, `FCS_A_MODE, {24'h0, codes[i]});
            apb(0, `FCS_A_MODE, 0);
            chk("mode reg", {21'h0, modes[i], codes[i]}, rd);
            chk("mode port", {29'h0, modes[i]}, {29'h0, sel});
        end
        // Lock on clock sync events, one tick per bus cycle
        apb(1, `FCS_A_TICKS, 32'h1);
        apb(1, `FCS_A_THR, 32'h2);
        apb(1, `FCS_A_IRQ_EN, 32'h3);
        apb(1, `FCS_A_CTRL, 32'h3);
        start_master(1'b1, 1000);
        repeat (3) wait_tick(n);
        apb(0, `FCS_A_MEAS, 0);
        chk("delay", 1, {31'h0, rd > 950 && rd < 1050});
        chk("locked", 1, {31'h0, locked});
        chk("irq gained", 1, {31'h0, irq});
        apb(1, `FCS_A_IRQ_CLR, 32'hF);
        // Let the clear settle before looking at the level output
        #1;
        chk("irq cleared", 0, {31'h0, irq});
        // Reference stops: lock and count drop, period back to nominal
        run <= 1'b0;
        repeat (3) wait_tick(n);
        apb(0, `FCS_A_STAT, 0);
        chk("stat", 0, rd);
        apb(0, `FCS_A_IRQ_ST, 0);
        chk("irq status", 32'h6, rd);
        // Align to a strobe first, then measure one whole period
        wait_tick(n);
        wait_tick(n);
        chk("free period", NOM, n);
        // Far out of phase: tick shrinks by the full step
        start_master(1'b1, 1500);
        wait_tick(n);
        wait_tick(n);
        chk("short period", NOM - ADJ, n);
        apb(0, `FCS_A_MEAS, 0);
        m1 = rd;
        wait_tick(n);
        apb(0, `FCS_A_MEAS, 0);
        chk("delay step", ADJ, m1 - rd);
        // Process data reference with distributed clocks off
        apb(1, `FCS_A_CTRL, 32'h1);
        start_master(1'b0, 1000);
        repeat (3) wait_tick(n);
        apb(0, `FCS_A_STAT, 0);
        chk("pd lock", 1, {31'h0, locked});
        oper <= 1'b0;
        repeat (3) wait_tick(n);
        apb(0, `FCS_A_STAT, 0);
        chk("not operational", 0, {31'h0, locked});
        // Interpolation strobe once per four-tick bus cycle, the shortest legal one
        apb(1, `FCS_A_TICKS, 32'h4);
        apb(1, `FCS_A_MODE, 32'h7);
        wait_tick(n);
        repeat (10) @(posedge pclk);
        i0 = n_interp;
        repeat (4) wait_tick(n);
        repeat (10) @(posedge pclk);
        chk("interp strobes", 1, n_interp - i0);
        end_of_test();
    end
endmodule
